// ===== mdc_decoder.sv
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - Energize shaft only while enable asserted
// - Disable transition lasts disable time
// - Input A level selects direction
// - Measure input B pulse frequency
// - Speed scales frequency over span times max
// - No pulses for timeout gives zero
// - A requests clockwise, B counter-clockwise
// - Removed request decelerates then holds
// - Same-direction repeat request ignored
// - Input change mid-move cancels and stops
// - After cancel accept only opposite direction
// - Two-position first homes to B switch
// - After homing follow A, move per toggle
// - Targets are signed offsets from home
// - A change mid-move stops, then retargets
// - Teach stores position under backup power
// - Option inverts home switch polarity
module mdc_decoder #(
  parameter int DISABLE_CYCLES = mdc_pkg::DISABLE_CYCLES,
  parameter int FREQ_TIMEOUT_CYCLES = mdc_pkg::FREQ_TIMEOUT_CYCLES,
  parameter int GATE_CYCLES = mdc_pkg::GATE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_pin_i,
  input wire logic in_a_pin_i,
  input wire logic in_b_pin_i,
  input wire logic at_rest_i,
  input wire logic signed [31:0] pos_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic energize_o,
  output logic fully_disabled_o,
  output logic run_o,
  output logic dir_cw_o,
  output logic [31:0] vel_cmd_o,
  output logic pos_move_o,
  output logic signed [31:0] pos_target_o,
  output logic home_set_o
);
  logic [2:0] en_s, a_s, b_s;
  logic en, a, b, a_q, b_q, b_rise;
  logic [31:0] ctrl, fmin, fspan, vmax;
  logic signed [31:0] tgt0, tgt1, home_pos;
  logic [31:0] gate_cnt, pulse_cnt, freq_hz, idle_cnt, dis_cnt;
  logic freq_off, homed, last_cw, have_last, en_q;
  logic [1:0] mode;
  logic home_inv, in_home, backup;
  logic [63:0] next_vel;
  logic [31:0] diff;
  mdc_pkg::mdc_state_e state;
  logic [31:0] rd;

  assign mode = ctrl[mdc_pkg::CTRL_MODE_LSB +: 2];
  assign home_inv = ctrl[mdc_pkg::CTRL_HOME_INV];
  assign backup = ctrl[mdc_pkg::CTRL_BACKUP];
  assign en = en_s[1];
  assign a = a_s[1];
  assign b = b_s[1];
  assign en_q = en_s[2];
  assign a_q = a_s[2];
  assign b_q = b_s[2];
  assign b_rise = b & ~b_q;
  assign in_home = home_inv ? ~b : b;

  // Second stage only feeds logic; third stage holds previous level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {en_s, a_s, b_s} <= 9'h000;
    else if (ce_i)
    begin
      en_s <= {en_s[1], en_s[0], enable_pin_i};
      a_s <= {a_s[1], a_s[0], in_a_pin_i};
      b_s <= {b_s[1], b_s[0], in_b_pin_i};
    end
  end

  // Wishbone slave, one wait state: ack the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= mdc_pkg::CTRL_RESET;
      fmin <= mdc_pkg::FMIN_RESET;
      fspan <= mdc_pkg::FSPAN_RESET;
      vmax <= mdc_pkg::VMAX_RESET;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        wb_dat_o <= rd;
        if (wb_we_i)
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (wb_sel_i[i])
            begin
              case (wb_adr_i)
                mdc_pkg::OFF_CTRL: ctrl[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                mdc_pkg::OFF_FMIN: fmin[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                mdc_pkg::OFF_FSPAN: fspan[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                mdc_pkg::OFF_VMAX: vmax[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                default: ;
              endcase
            end
          end
        end
      end
    end
  end

  always_comb
  begin
    case (wb_adr_i)
      mdc_pkg::OFF_CTRL: rd = ctrl;
      mdc_pkg::OFF_FMIN: rd = fmin;
      mdc_pkg::OFF_FSPAN: rd = fspan;
      mdc_pkg::OFF_VMAX: rd = vmax;
      mdc_pkg::OFF_TGT0: rd = tgt0;
      mdc_pkg::OFF_TGT1: rd = tgt1;
      mdc_pkg::OFF_POS: rd = pos_i - home_pos;
      mdc_pkg::OFF_STAT: rd = {24'h00_0000, state == mdc_pkg::MDC_HOLD, homed, fully_disabled_o,
                               energize_o, freq_off, last_cw, have_last, en};
      mdc_pkg::OFF_FREQ: rd = freq_hz;
      mdc_pkg::OFF_VEL: rd = vel_cmd_o;
      default: rd = 32'h0000_0000;
    endcase
  end

  // Target registers: software writes, or teach on enable rise under backup power
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tgt0 <= 32'sh0000_0000;
      tgt1 <= 32'sh0000_0000;
    end
    else if (ce_i)
    begin
      if (backup && en && !en_q && mode == mdc_pkg::MODE_TWOPOS)
      begin
        if (a)
          tgt1 <= pos_i - home_pos;
        else
          tgt0 <= pos_i - home_pos;
      end
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == mdc_pkg::OFF_TGT0)
        tgt0 <= wb_dat_i;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == mdc_pkg::OFF_TGT1)
        tgt1 <= wb_dat_i;
    end
  end

  // Gate-time counter: pulses counted over a 50 ms gate scaled to hertz
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_cnt <= 32'h0000_0000;
      pulse_cnt <= 32'h0000_0000;
      freq_hz <= 32'h0000_0000;
      idle_cnt <= 32'h0000_0000;
      freq_off <= 1'b1;
    end
    else if (ce_i)
    begin
      if (gate_cnt == 32'(GATE_CYCLES - 1))
      begin
        gate_cnt <= 32'h0000_0000;
        pulse_cnt <= 32'(b_rise);
        freq_hz <= 32'(pulse_cnt * (1000 / mdc_pkg::GATE_TIME_MS));
      end
      else
      begin
        gate_cnt <= gate_cnt + 32'h0000_0001;
        pulse_cnt <= pulse_cnt + 32'(b_rise);
      end
      if (b_rise)
      begin
        idle_cnt <= 32'h0000_0000;
        freq_off <= 1'b0;
      end
      else if (idle_cnt >= 32'(FREQ_TIMEOUT_CYCLES - 1))
        freq_off <= 1'b1;
      else
        idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  assign diff = (freq_hz > fmin) ? freq_hz - fmin : 32'h0000_0000;
  // Divide costs area and is combinational; vel_cmd_o samples it every cycle in frequency mode, so it must close in one cycle
  assign next_vel = (fspan == 32'h0000_0000) ? 64'h0 : (64'(diff) * 64'(vmax)) / 64'(fspan);

  // Enable and disable sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      energize_o <= 1'b0;
      fully_disabled_o <= 1'b1;
      dis_cnt <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      energize_o <= en && !backup;
      if (en)
      begin
        fully_disabled_o <= 1'b0;
        dis_cnt <= 32'h0000_0000;
      end
      else if (!fully_disabled_o)
      begin
        if (dis_cnt == 32'(DISABLE_CYCLES - 1))
          fully_disabled_o <= 1'b1;
        else
          dis_cnt <= dis_cnt + 32'h0000_0001;
      end
    end
  end

  // Mode sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= mdc_pkg::MDC_IDLE;
      run_o <= 1'b0;
      dir_cw_o <= 1'b0;
      vel_cmd_o <= 32'h0000_0000;
      pos_move_o <= 1'b0;
      pos_target_o <= 32'sh0000_0000;
      home_set_o <= 1'b0;
      home_pos <= 32'sh0000_0000;
      homed <= 1'b0;
      last_cw <= 1'b0;
      have_last <= 1'b0;
    end
    else if (ce_i)
    begin
      home_set_o <= 1'b0;
      if (!en || backup)
      begin
        state <= en ? mdc_pkg::MDC_IDLE : mdc_pkg::MDC_DISABLING;
        run_o <= 1'b0;
        vel_cmd_o <= 32'h0000_0000;
        pos_move_o <= 1'b0;
        homed <= 1'b0;
      end
      else
      begin
        case (mode)
          mdc_pkg::MODE_FREQ:
          begin
            state <= mdc_pkg::MDC_MOVE;
            dir_cw_o <= a;
            vel_cmd_o <= freq_off ? 32'h0000_0000 : next_vel[31:0];
            run_o <= !freq_off;
            pos_move_o <= 1'b0;
          end
          mdc_pkg::MODE_SENSOR:
          begin
            pos_move_o <= 1'b0;
            vel_cmd_o <= vmax;
            case (state)
              mdc_pkg::MDC_MOVE:
                if (a != a_q || b != b_q || !(dir_cw_o ? a : b))
                begin
                  run_o <= 1'b0;
                  state <= mdc_pkg::MDC_STOPPING;
                end
              mdc_pkg::MDC_STOPPING:
                if (at_rest_i)
                  state <= mdc_pkg::MDC_HOLD;
              default:
              begin
                run_o <= 1'b0;
                state <= mdc_pkg::MDC_HOLD;
                if (a && !b && !(have_last && last_cw))
                begin
                  dir_cw_o <= 1'b1;
                  last_cw <= 1'b1;
                  have_last <= 1'b1;
                  run_o <= 1'b1;
                  state <= mdc_pkg::MDC_MOVE;
                end
                else if (b && !a && !(have_last && !last_cw))
                begin
                  dir_cw_o <= 1'b0;
                  last_cw <= 1'b0;
                  have_last <= 1'b1;
                  run_o <= 1'b1;
                  state <= mdc_pkg::MDC_MOVE;
                end
              end
            endcase
          end
          mdc_pkg::MODE_TWOPOS:
          begin
            vel_cmd_o <= vmax;
            case (state)
              mdc_pkg::MDC_HOMING:
              begin
                dir_cw_o <= 1'b0;
                run_o <= 1'b1;
                if (in_home)
                begin
                  run_o <= 1'b0;
                  home_pos <= pos_i;
                  home_set_o <= 1'b1;
                  homed <= 1'b1;
                  state <= mdc_pkg::MDC_STOPPING;
                end
              end
              mdc_pkg::MDC_MOVE:
                if (a != a_q)
                begin
                  pos_move_o <= 1'b0;
                  state <= mdc_pkg::MDC_STOPPING;
                end
                else if (at_rest_i && pos_move_o && pos_i == pos_target_o)
                begin
                  pos_move_o <= 1'b0;
                  state <= mdc_pkg::MDC_HOLD;
                end
              mdc_pkg::MDC_STOPPING:
                if (at_rest_i)
                begin
                  pos_target_o <= home_pos + (a ? tgt1 : tgt0);
                  pos_move_o <= 1'b1;
                  state <= mdc_pkg::MDC_MOVE;
                end
              mdc_pkg::MDC_HOLD:
                if (a != a_q)
                begin
                  pos_target_o <= home_pos + (a ? tgt1 : tgt0);
                  pos_move_o <= 1'b1;
                  state <= mdc_pkg::MDC_MOVE;
                end
              default:
                state <= homed ? mdc_pkg::MDC_HOLD : mdc_pkg::MDC_HOMING;
            endcase
          end
          default:
          begin
            run_o <= 1'b0;
            pos_move_o <= 1'b0;
            state <= mdc_pkg::MDC_IDLE;
          end
        endcase
      end
    end
  end
endmodule : mdc_decoder

// ===== mdc_pkg.sv
package mdc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FMIN = 8'h04;
  localparam logic [7:0] OFF_FSPAN = 8'h08;
  localparam logic [7:0] OFF_VMAX = 8'h0C;
  localparam logic [7:0] OFF_TGT0 = 8'h10;
  localparam logic [7:0] OFF_TGT1 = 8'h14;
  localparam logic [7:0] OFF_POS = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_FREQ = 8'h20;
  localparam logic [7:0] OFF_VEL = 8'h24;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HOME_INV = 2;
  localparam int CTRL_BACKUP = 3;
  localparam int CTRL_AT_HOME = 4;
  localparam int CTRL_AT_TARGET = 5;
  localparam int CTRL_STOPPED = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FMIN_RESET = 32'h0000_0000;
  localparam logic [31:0] FSPAN_RESET = 32'h0007_A120;
  localparam logic [31:0] VMAX_RESET = 32'h0000_0FA0;
  // Modes
  localparam logic [1:0] MODE_FREQ = 2'h0;
  localparam logic [1:0] MODE_SENSOR = 2'h1;
  localparam logic [1:0] MODE_TWOPOS = 2'h2;
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int DISABLE_TIME_MS = 10;
  localparam int FREQ_TIMEOUT_MS = 50;
  localparam int GATE_TIME_MS = 50;
  localparam int DISABLE_CYCLES = CLK_HZ / 1000 * DISABLE_TIME_MS;
  localparam int FREQ_TIMEOUT_CYCLES = CLK_HZ / 1000 * FREQ_TIMEOUT_MS;
  localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_TIME_MS;
  // Frequency range accepted on input B
  localparam int FREQ_MIN_HZ = 20;
  localparam int FREQ_MAX_HZ = 500_000;
  typedef enum logic [5:0] {
    MDC_IDLE = 6'b00_0001,
    MDC_HOMING = 6'b00_0010,
    MDC_MOVE = 6'b00_0100,
    MDC_STOPPING = 6'b00_1000,
    MDC_HOLD = 6'b01_0000,
    MDC_DISABLING = 6'b10_0000
  } mdc_state_e;
endpackage : mdc_pkg

// ===== mdc_decoder_props.sv
`timescale 1ns/100ps
module mdc_decoder_props #(
  parameter int DISABLE_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic energize_o,
  input wire logic fully_disabled_o,
  input wire logic run_o,
  input wire logic pos_move_o,
  input wire logic home_set_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] low_cnt;
  // Saturates so a long idle never wraps into a false short count
  always_ff @(posedge clk_i)
  begin
    if (rst_i || enable_pin_i)
      low_cnt <= 32'h0000_0000;
    else if (low_cnt != 32'hFFFF_FFFF)
      low_cnt <= low_cnt + 32'h0000_0001;
  end
  property p_deenergize;
    (!enable_pin_i) [*5] |-> !energize_o;
  endproperty
  a_deenergize: assert property (p_deenergize) else $error("shaft energised with enable low");
  property p_energize_cause;
    $rose(energize_o) |-> $past(enable_pin_i, 3);
  endproperty
  a_energize_cause: assert property (p_energize_cause) else $error("shaft energised without enable");
  property p_disable_early;
    $rose(fully_disabled_o) |-> low_cnt >= DISABLE_CYCLES;
  endproperty
  a_disable_early: assert property (p_disable_early) else $error("disable finished too soon");
  property p_disable_late;
    low_cnt == DISABLE_CYCLES + 6 |-> fully_disabled_o;
  endproperty
  a_disable_late: assert property (p_disable_late) else $error("disable not finished in time");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus access not acked next cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_unmapped_zero;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h27 |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_home_pulse;
    home_set_o |=> !home_set_o;
  endproperty
  a_home_pulse: assert property (p_home_pulse) else $error("home capture not a single pulse");
  c_run: cover property ($rose(run_o));
  c_home: cover property (home_set_o);
  c_disabled: cover property ($rose(fully_disabled_o));
  c_pos_move: cover property ($rose(pos_move_o));
endmodule : mdc_decoder_props
bind mdc_decoder mdc_decoder_props #(.DISABLE_CYCLES(DISABLE_CYCLES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .enable_pin_i(enable_pin_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .energize_o(energize_o),
  .fully_disabled_o(fully_disabled_o), .run_o(run_o), .pos_move_o(pos_move_o), .home_set_o(home_set_o)
);

// ===== mdc_plc.sv
`timescale 1ns/100ps
module mdc_plc #(
  parameter int HALF = 5
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic pulse_i,
  output logic enable_pin_o,
  output logic in_a_pin_o,
  output logic in_b_pin_o
);
  logic en_q;
  int cnt = 0;
  // Enable trails A by a cycle so a teach always sees A settled
  always_ff @(posedge clk_i)
  begin
    en_q <= en_i;
    enable_pin_o <= en_q;
    in_a_pin_o <= a_i;
  end
  // Scaled time base: period of 2*HALF cycles stands for an in-range rate
  always_ff @(posedge clk_i)
  begin
    cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
    if (!pulse_i)
      in_b_pin_o <= b_i;
    else if (cnt >= HALF - 1)
      in_b_pin_o <= !in_b_pin_o;
  end
endmodule : mdc_plc

// ===== mdc_decoder_bench.sv
`timescale 1ns/100ps
module mdc_decoder_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0;
  logic a = 1'b0;
  logic b = 1'b0;
  logic pulse = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic signed [31:0] pos = 32'sh0000_03E8;
  logic en_pin, a_pin, b_pin, at_rest, ack, energize, fully_dis, run, cw, pos_move, home_set;
  logic [31:0] rdat, vel;
  logic signed [31:0] target;
  int n_fail = 0;
  int tests_run = 0;
  int homes = 0;
  always #2.5 clk_i = ~clk_i;
  // Motion core stand-in: steps one count a cycle toward the target
  assign at_rest = !run && (!pos_move || pos == target);
  always @(posedge clk_i)
    if (pos_move && !run && pos != target)
      pos <= (target > pos) ? pos + 32'sh0000_0001 : pos - 32'sh0000_0001;
  always @(posedge clk_i)
    if (home_set === 1'b1)
      homes <= homes + 1;
  mdc_plc plc (.clk_i(clk_i), .en_i(en), .a_i(a), .b_i(b), .pulse_i(pulse),
    .enable_pin_o(en_pin), .in_a_pin_o(a_pin), .in_b_pin_o(b_pin));
  mdc_decoder #(.DISABLE_CYCLES(20), .FREQ_TIMEOUT_CYCLES(50), .GATE_CYCLES(100)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .enable_pin_i(en_pin), .in_a_pin_i(a_pin), .in_b_pin_i(b_pin),
    .at_rest_i(at_rest), .pos_i(pos), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .energize_o(energize),
    .fully_disabled_o(fully_dis), .run_o(run), .dir_cw_o(cw), .vel_cmd_o(vel), .pos_move_o(pos_move),
    .pos_target_o(target), .home_set_o(home_set));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task final_report;
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    chk(n < 20, 1'b1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, 4'hF);
  endtask : wr
  task rdc(input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0000_0000, 4'hF);
    chk(rdat, exp, "register read");
  endtask : rdc
  task reset_dut;
    rst_i <= 1'b1;
    en <= 1'b0;
    a <= 1'b0;
    b <= 1'b0;
    pulse <= 1'b0;
    pos <= 32'sh0000_03E8;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : reset_dut
  task pins(input logic na, input logic nb, input int w);
    a <= na;
    b <= nb;
    repeat (w) @(posedge clk_i);
  endtask : pins
  task t_regs;
    rdc(mdc_pkg::OFF_CTRL, mdc_pkg::CTRL_RESET);
    rdc(mdc_pkg::OFF_FSPAN, mdc_pkg::FSPAN_RESET);
    xfer(1'b1, mdc_pkg::OFF_VMAX, 32'hFFFF_FFFF, 4'h1);
    rdc(mdc_pkg::OFF_VMAX, 32'h0000_0FFF);
    wr(8'h40, 32'h1234_5678);
    rdc(8'h40, 32'h0000_0000);
  endtask : t_regs
  task t_freq;
    reset_dut;
    wr(mdc_pkg::OFF_VMAX, 32'h0000_0FA0);
    wr(mdc_pkg::OFF_FSPAN, 32'h0000_0190);
    en <= 1'b1;
    a <= 1'b1;
    pulse <= 1'b1;
    repeat (400) @(posedge clk_i);
    chk(energize, 1'b1, "energise");
    chk(cw, 1'b1, "direction");
    chk(vel, 32'h0000_07D0, "speed");
    rdc(mdc_pkg::OFF_FREQ, 32'h0000_00C8);
    wr(mdc_pkg::OFF_FMIN, 32'h0000_0064);
    pins(1'b0, 1'b0, 250);
    chk(cw, 1'b0, "direction");
    chk(vel, 32'h0000_03E8, "speed");
    pulse <= 1'b0;
    repeat (80) @(posedge clk_i);
    chk(run, 1'b0, "pulse timeout run");
    chk(vel, 32'h0000_0000, "pulse timeout speed");
    en <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({energize, fully_dis}, 2'b00, "disabling");
    repeat (30) @(posedge clk_i);
    chk(fully_dis, 1'b1, "fully disabled");
  endtask : t_freq
  task t_sensor;
    reset_dut;
    wr(mdc_pkg::OFF_CTRL, 32'h0000_0001);
    en <= 1'b1;
    pins(1'b1, 1'b0, 10);
    chk({run, cw}, 2'b11, "cw move");
    pins(1'b0, 1'b0, 8);
    chk(run, 1'b0, "switch stop");
    pins(1'b1, 1'b0, 8);
    chk(run, 1'b0, "repeat ignored");
    pins(1'b0, 1'b1, 8);
    chk({run, cw}, 2'b10, "ccw move");
    pins(1'b1, 1'b1, 6);
    chk(run, 1'b0, "cancel");
    pins(1'b0, 1'b0, 8);
    pins(1'b0, 1'b1, 8);
    chk(run, 1'b0, "same after cancel");
    pins(1'b1, 1'b0, 8);
    chk({run, cw}, 2'b11, "opposite after cancel");
  endtask : t_sensor
  task t_twopos;
    for (int inv = 0; inv < 2; inv++)
    begin
      reset_dut;
      wr(mdc_pkg::OFF_CTRL, inv ? 32'h0000_0006 : 32'h0000_0002);
      wr(mdc_pkg::OFF_TGT0, 32'h0000_0064);
      wr(mdc_pkg::OFF_TGT1, 32'hFFFF_FFCE);
      pins(1'b1, inv[0], 4);
      en <= 1'b1;
      repeat (12) @(posedge clk_i);
      chk({run, cw}, 2'b10, "homing");
      pins(1'b1, !inv[0], 150);
      chk(homes, inv + 1, "home found");
      chk(pos, 32'h0000_03B6, "first target");
      pins(1'b0, !inv[0], 200);
      chk(pos, 32'h0000_044C, "toggle target");
      pins(1'b1, !inv[0], 30);
      pins(1'b0, !inv[0], 10);
      chk(target, 32'h0000_044C, "retarget");
      repeat (100) @(posedge clk_i);
      chk(pos, 32'h0000_044C, "retarget reached");
      en <= 1'b0;
      repeat (30) @(posedge clk_i);
    end
    wr(mdc_pkg::OFF_CTRL, 32'h0000_000E);
    pos <= 32'sh0000_04D2;
    pins(1'b0, 1'b1, 4);
    en <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(energize, 1'b0, "teach keeps shaft off");
    rdc(mdc_pkg::OFF_TGT0, 32'h0000_00EA);
  endtask : t_twopos
  initial
  begin
    #100000;
    n_fail++;
    final_report;
  end
  initial
  begin
    reset_dut;
    t_regs;
    t_freq;
    t_sensor;
    t_twopos;
    final_report;
  end
endmodule : mdc_decoder_bench
